// ---- verilog/control_input_function_mapper.sv ----
// Purpose: Qualifies general-purpose contact inputs into drive functions.
// Assumes: Classic Wishbone slave, one clock, synchronous reset.
// Notes: Outputs are registered; one cycle Wishbone answer latency.
// Notes: One address decode is shared by the read and write paths.
`timescale 1ns/1ns
module control_input_function_mapper (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [ctl_in_pkg::N_INPUTS-1:0] gp_input_i,
  input wire logic [1:0] control_mode_i,
  output logic servo_enable_o,
  output logic positive_overtravel_inhibit_o,
  output logic negative_overtravel_inhibit_o,
  output logic overtravel_alarm_o,
  output logic deviation_clear_o,
  output logic map_error_o,
  output logic irq_o
);
  import ctl_in_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    // Software-visible configuration and status
    logic [N_INPUTS-1:0][31:0] fsel;
    logic [3:0] ot_setup;
    logic [3:0] clr_mode;
    logic [N_EVENTS-1:0] irq_stat;
    logic [N_EVENTS-1:0] irq_mask;

    // Bus answer
    logic ack;
    logic [31:0] rdata;

    // Qualified function levels
    logic servo_en;
    logic pos_inh;
    logic neg_inh;
    logic ot_alarm;
    logic dev_clr;
    logic map_err;
    logic irq;

    // Edge history of decoded functions
    logic cl_prev;
    logic pot_prev;
    logic not_prev;
  } map_state_s;

  map_state_s r_reg;
  map_state_s r_next;

  // Register targets of the bus address
  typedef enum logic [2:0] {
    REG_FSEL = 3'h0,
    REG_OT = 3'h1,
    REG_CLR = 3'h2,
    REG_STATUS = 3'h3,
    REG_ISTAT = 3'h4,
    REG_IMASK = 3'h5,
    REG_NONE = 3'h6
  } reg_e;

  logic [N_INPUTS-1:0] in_sync;
  logic fn_servo;
  logic fn_pos_ot;
  logic fn_neg_ot;
  logic fn_clear;
  logic fn_misplaced;

  logic bus_req;
  logic bus_wr;
  logic [5:0] word_idx;
  logic [31:0] wmask;
  reg_e reg_hit;
  logic [N_EVENTS-1:0] events;
  logic [N_EVENTS-1:0] w1c;
  logic ot_enabled;
  logic clr_level_mode;
  logic clr_rise;

  // ------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------
  // Pins cross into the clock domain before any decode
  input_sync #(
    .WIDTH(N_INPUTS)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(gp_input_i),
    .sync_o(in_sync)
  );

  // ------------------------------------------------------------
  // Function routing
  // ------------------------------------------------------------
  // Routing follows the select registers of the active mode
  func_lookup #(
    .N(N_INPUTS)
  ) u_lookup (
    .fsel_i(r_reg.fsel),
    .level_i(in_sync),
    .mode_i(control_mode_i),
    .servo_o(fn_servo),
    .pos_ot_o(fn_pos_ot),
    .neg_ot_o(fn_neg_ot),
    .clear_o(fn_clear),
    .misplaced_o(fn_misplaced)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Expand Wishbone byte selects into a bit mask
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = '0;
    for (int k = 0; k < 4; k++) begin
      m[8*k +: 8] = {8{sel[k]}};
    end
    return m;
  endfunction

  // Merge masked write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [31:0] mask);
    return (old & ~mask) | (data & mask);
  endfunction

  // Address decode, select words fill the low word indices
  function automatic reg_e reg_decode(input logic [7:0] adr);
    reg_e r;
    if (adr[7:2] < 6'(N_INPUTS)) begin
      r = REG_FSEL;
    end else begin
      unique case (adr)
        ADDR_OT_SETUP: r = REG_OT;
        ADDR_CLR_MODE: r = REG_CLR;
        ADDR_STATUS: r = REG_STATUS;
        ADDR_IRQ_STAT: r = REG_ISTAT;
        ADDR_IRQ_MASK: r = REG_IMASK;
        default: r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  // Live status word of qualified functions and inputs
  function automatic logic [31:0] status_word(
    input map_state_s s,
    input logic [N_INPUTS-1:0] pins
  );
    logic [31:0] w;
    w = '0;
    w[0] = s.servo_en;
    w[1] = s.pos_inh;
    w[2] = s.neg_inh;
    w[3] = s.ot_alarm;
    w[4] = s.dev_clr;
    w[5] = s.map_err;
    w[16 +: N_INPUTS] = pins;
    return w;
  endfunction

  // Read value of the decoded register, zero where unmapped
  function automatic logic [31:0] read_word(
    input reg_e sel,
    input map_state_s s,
    input logic [3:0] idx,
    input logic [N_INPUTS-1:0] pins
  );
    logic [31:0] w;
    w = '0;
    unique case (sel)
      REG_FSEL: w = s.fsel[idx];
      REG_OT: w[3:0] = s.ot_setup;
      REG_CLR: w[3:0] = s.clr_mode;
      REG_STATUS: w = status_word(s, pins);
      REG_ISTAT: w[N_EVENTS-1:0] = s.irq_stat;
      REG_IMASK: w[N_EVENTS-1:0] = s.irq_mask;
      default: w = '0;
    endcase
    return w;
  endfunction

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Request seen; write committed on the acknowledged cycle
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr = bus_req && wb_we_i && r_reg.ack;
  assign word_idx = wb_adr_i[7:2];
  assign wmask = sel_mask(wb_sel_i);

  // One address decode serves reads and writes
  assign reg_hit = reg_decode(wb_adr_i);

  // Write-one-to-clear of interrupt status
  assign w1c = (bus_wr && (reg_hit == REG_ISTAT) && wb_sel_i[0]) ?
               wb_dat_i[N_EVENTS-1:0] : '0;

  // ------------------------------------------------------------
  // Qualification terms
  // ------------------------------------------------------------
  // Over-travel acts only when setup is not the disabling value
  assign ot_enabled = (r_reg.ot_setup != OT_DISABLED);

  // Clear modes 1 and 2 hold, others clear once on the rise
  assign clr_level_mode = (r_reg.clr_mode == CLR_LEVEL_A) ||
                          (r_reg.clr_mode == CLR_LEVEL_B);
  assign clr_rise = fn_clear && !r_reg.cl_prev;

  // Events that set sticky status bits
  always_comb begin
    events = '0;
    events[EV_POS_OT] = fn_pos_ot && !r_reg.pot_prev;
    events[EV_NEG_OT] = fn_neg_ot && !r_reg.not_prev;
    events[EV_CLEAR] = clr_rise;
    events[EV_MAP_ERR] = fn_misplaced && !r_reg.map_err;
    events[EV_SERVO] = fn_servo != r_reg.servo_en;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;

    // One-cycle acknowledge, dropped the cycle after
    r_next.ack = bus_req && !r_reg.ack;

    // Read data captured together with the acknowledge
    r_next.rdata = '0;
    if (bus_req && !r_reg.ack && !wb_we_i) begin
      r_next.rdata = read_word(reg_hit, r_reg, word_idx[3:0], in_sync);
    end

    // Register writes, byte lanes honoured
    if (bus_wr) begin
      unique case (reg_hit)
        REG_FSEL: begin
          r_next.fsel[word_idx[3:0]] =
            merge(r_reg.fsel[word_idx[3:0]], wb_dat_i, wmask);
        end
        REG_OT: begin
          if (wb_sel_i[0]) begin
            r_next.ot_setup = wb_dat_i[3:0];
          end
        end
        REG_CLR: begin
          if (wb_sel_i[0]) begin
            r_next.clr_mode = wb_dat_i[3:0];
          end
        end
        REG_IMASK: begin
          if (wb_sel_i[0]) begin
            r_next.irq_mask = wb_dat_i[N_EVENTS-1:0];
          end
        end
        default: begin
          // Live status word and unmapped addresses ignore writes; interrupt status clears through w1c
        end
      endcase
    end

    // Servo enable follows its qualified input
    r_next.servo_en = fn_servo;

    // Over-travel inhibit, gated by setup
    r_next.pos_inh = fn_pos_ot && ot_enabled;
    r_next.neg_inh = fn_neg_ot && ot_enabled;
    r_next.ot_alarm = (fn_pos_ot || fn_neg_ot) &&
                      (r_reg.ot_setup == OT_ALARM);

    // Deviation counter clear strobe or hold
    if (clr_level_mode) begin
      r_next.dev_clr = fn_clear;
    end else begin
      r_next.dev_clr = clr_rise;
    end

    // Clear allocated to a wrong input
    r_next.map_err = fn_misplaced;

    // Edge history
    r_next.cl_prev = fn_clear;
    r_next.pot_prev = fn_pos_ot;
    r_next.not_prev = fn_neg_ot;

    // Sticky status: a new event wins over a clear
    r_next.irq_stat = (r_reg.irq_stat & ~w1c) | events;

    // Level interrupt from unmasked status
    r_next.irq = |(r_next.irq_stat & r_next.irq_mask);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.fsel <= FSEL_RESET;
      r_reg.ot_setup <= OT_SETUP_RESET;
      r_reg.clr_mode <= CLR_MODE_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Bus answer straight from the state register
  assign wb_dat_o = r_reg.rdata;
  assign wb_ack_o = r_reg.ack;

  // Qualified function levels, all registered
  assign servo_enable_o = r_reg.servo_en;
  assign positive_overtravel_inhibit_o = r_reg.pos_inh;
  assign negative_overtravel_inhibit_o = r_reg.neg_inh;
  assign overtravel_alarm_o = r_reg.ot_alarm;
  assign deviation_clear_o = r_reg.dev_clr;
  assign map_error_o = r_reg.map_err;

  // Level interrupt from the registered flag
  assign irq_o = r_reg.irq;

endmodule

// ---- verilog/ctl_in_pkg.sv ----
// Purpose: Shared constants for the control input function mapper.
// Assumes: One 250 MHz clock, classic Wishbone register access.
// Notes: Each select byte holds polarity in bit 7, function code below.
//
// Contract
// - Any function but clear routable to any input, per-input polarity
// - Normally-open input: closed to common means on
// - Normally-closed input: open from common means on
// - Servo enable drives energisation, default input six
// - Over-travel on takes action chosen by setup
// - Deviation clear zeroes positional deviation counter
// - Default rising-edge clear; mode parameter changes it
// - Modes 1,2 hold clear; 3,4 clear once
// - Clear only on input seven, else error
package ctl_in_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int N_INPUTS = 10;
  localparam int SYNC_STAGES = 2;
  localparam int N_EVENTS = 5;

  // ------------------------------------------------------------
  // Select byte layout and control mode byte positions
  // ------------------------------------------------------------
  localparam int POL_BIT = 7;
  localparam int CODE_MSB = 6;
  localparam int BYTE_POS_MODE = 0;
  localparam int BYTE_VEL_MODE = 1;
  localparam int BYTE_TRQ_MODE = 2;
  localparam int CLEAR_INPUT_IDX = 6;

  // Control modes presented by the servo core
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_VELOCITY = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;

  // Function codes decoded here
  localparam logic [6:0] FN_POS_OT = 7'h01;
  localparam logic [6:0] FN_NEG_OT = 7'h02;
  localparam logic [6:0] FN_SERVO = 7'h03;
  localparam logic [6:0] FN_CLEAR = 7'h07;

  // ------------------------------------------------------------
  // Register word offsets (byte address)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_FSEL_BASE = 8'h00;
  localparam logic [7:0] ADDR_OT_SETUP = 8'h28;
  localparam logic [7:0] ADDR_CLR_MODE = 8'h2C;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h34;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h38;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [N_INPUTS-1:0][31:0] FSEL_RESET = {
    32'h00000E88, 32'h00050505, 32'h00040404, 32'h00000F07,
    32'h00030303, 32'h0000100C, 32'h00060606, 32'h0091910A,
    32'h00818181, 32'h00828282
  };
  localparam logic [3:0] OT_SETUP_RESET = 4'h1;
  localparam logic [3:0] CLR_MODE_RESET = 4'h3;

  // Over-travel setup values
  localparam logic [3:0] OT_DISABLED = 4'h1;
  localparam logic [3:0] OT_ALARM = 4'h2;

  // Clear mode values
  localparam logic [3:0] CLR_LEVEL_A = 4'h1;
  localparam logic [3:0] CLR_LEVEL_B = 4'h2;

  // Event bit positions
  localparam int EV_POS_OT = 0;
  localparam int EV_NEG_OT = 1;
  localparam int EV_CLEAR = 2;
  localparam int EV_MAP_ERR = 3;
  localparam int EV_SERVO = 4;

endpackage

// ---- verilog/input_sync.sv ----
// Purpose: Two-stage synchroniser for asynchronous contact inputs.
// Assumes: Inputs are static levels from isolated contacts.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ns
module input_sync #(
  parameter int WIDTH = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import ctl_in_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s r_reg;
  sync_s r_next;

  // Shift stage one into stage two
  always_comb begin
    r_next = r_reg;
    r_next.meta = async_i;
    r_next.stable = r_reg.meta;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sync_o = r_reg.stable;

endmodule

// ---- verilog/func_lookup.sv ----
// Purpose: Routes synchronised inputs onto decoded functions.
// Assumes: Input level high means contact closed to common.
// Notes: Purely combinational; caller registers the results.
`timescale 1ns/1ns
module func_lookup #(
  parameter int N = 10
) (
  input wire logic [N-1:0][31:0] fsel_i,
  input wire logic [N-1:0] level_i,
  input wire logic [1:0] mode_i,
  output logic servo_o,
  output logic pos_ot_o,
  output logic neg_ot_o,
  output logic clear_o,
  output logic misplaced_o
);
  import ctl_in_pkg::*;

  logic [N-1:0] srv_hit;
  logic [N-1:0] pot_hit;
  logic [N-1:0] not_hit;
  logic [N-1:0] clr_hit;
  logic [N-1:0] bad_hit;

  // Pick the select byte of the active control mode
  function automatic logic [7:0] mode_byte(input logic [31:0] cfg,
                                           input logic [1:0] mode);
    logic [7:0] b;
    unique case (mode)
      MODE_VELOCITY: b = cfg[8*BYTE_VEL_MODE +: 8];
      MODE_TORQUE: b = cfg[8*BYTE_TRQ_MODE +: 8];
      default: b = cfg[8*BYTE_POS_MODE +: 8];
    endcase
    return b;
  endfunction

  // Per-input polarity and code match
  generate
    for (genvar i = 0; i < N; i++) begin : g_in
      logic [7:0] b;
      logic act;
      assign b = mode_byte(fsel_i[i], mode_i);
      assign act = level_i[i] ^ b[POL_BIT];
      assign srv_hit[i] = act && (b[CODE_MSB:0] == FN_SERVO);
      assign pot_hit[i] = act && (b[CODE_MSB:0] == FN_POS_OT);
      assign not_hit[i] = act && (b[CODE_MSB:0] == FN_NEG_OT);
      if (i == CLEAR_INPUT_IDX) begin : g_clr
        assign clr_hit[i] = act && (b[CODE_MSB:0] == FN_CLEAR);
        assign bad_hit[i] = 1'b0;
      end else begin : g_noclr
        assign clr_hit[i] = 1'b0;
        assign bad_hit[i] = (b[CODE_MSB:0] == FN_CLEAR);
      end
    end
  endgenerate

  // Unassigned functions reduce to off
  assign servo_o = |srv_hit;
  assign pos_ot_o = |pot_hit;
  assign neg_ot_o = |not_hit;
  assign clear_o = |clr_hit;
  assign misplaced_o = |bad_hit;

endmodule

// ---- dv/ctl_in_monitor.sv ----
// Purpose: Port-level checks of the control input mapper.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound onto the top module below.
`timescale 1ns/1ns
module ctl_in_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [ctl_in_pkg::N_INPUTS-1:0] gp_input_i,
  input wire logic [1:0] control_mode_i,
  input wire logic servo_enable_o,
  input wire logic positive_overtravel_inhibit_o,
  input wire logic negative_overtravel_inhibit_o,
  input wire logic overtravel_alarm_o,
  input wire logic deviation_clear_o,
  input wire logic map_error_o,
  input wire logic irq_o
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_latency:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_cause:
    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_idle_data_zero:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");
  a_reset_quiet:
    assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=>
      !wb_ack_o && !servo_enable_o && !positive_overtravel_inhibit_o &&
      !negative_overtravel_inhibit_o && !overtravel_alarm_o &&
      !deviation_clear_o && !map_error_o && !irq_o)
    else $error("outputs active in reset");
  a_alarm_cause:
    assert property (overtravel_alarm_o |->
      positive_overtravel_inhibit_o || negative_overtravel_inhibit_o)
    else $error("alarm without over-travel function");
  a_outputs_settle:
    assert property ((!wb_cyc_i && $stable(gp_input_i) &&
      $stable(control_mode_i))[*6] |=> $stable({servo_enable_o,
      positive_overtravel_inhibit_o, negative_overtravel_inhibit_o,
      overtravel_alarm_o, map_error_o}))
    else $error("function outputs move with quiet inputs");
  a_clear_settles:
    assert property ((!wb_cyc_i && $stable(gp_input_i) &&
      $stable(control_mode_i))[*6] |=> $stable(deviation_clear_o))
    else $error("clear output moves with quiet inputs");
endmodule

bind control_input_function_mapper ctl_in_monitor u_ctl_in_monitor (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .gp_input_i,
  .control_mode_i, .servo_enable_o, .positive_overtravel_inhibit_o,
  .negative_overtravel_inhibit_o, .overtravel_alarm_o, .deviation_clear_o,
  .map_error_o, .irq_o
);

// ---- dv/contact_host.sv ----
// Purpose: Host controller closing input contacts to common.
// Assumes: High level means contact closed to common.
// Notes: A new pattern lands after a settable lag.
`timescale 1ns/1ns
module contact_host (
  input wire logic clk_i,
  input wire logic [9:0] want_i,
  input wire logic [3:0] lag_i,
  output logic [9:0] contact_o
);
  // ------------------------------------------------------------
  // Contact switching
  // ------------------------------------------------------------
  logic [3:0] wait_reg;
  // Inhibit contacts closed while in range, servo contact open
  initial contact_o = 10'h003;
  initial wait_reg = 4'h0;
  // Hold a new pattern back until the lag runs out
  always @(posedge clk_i) begin
    if (want_i === contact_o) begin
      wait_reg <= 4'h0;
    end else if (wait_reg >= lag_i) begin
      contact_o <= want_i;
      wait_reg <= 4'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the control input mapper.
// Assumes: Contact host model drives the input pins.
// Notes: Random routing with a fixed seed plus corner cases.
`timescale 1ns/1ns
module tb;
  import ctl_in_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and design
  // ------------------------------------------------------------
  localparam logic [6:0] CODES [5] = '{FN_POS_OT, FN_NEG_OT, FN_SERVO,
    FN_CLEAR, 7'h0C};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [9:0] want = 10'h003;
  logic [3:0] lag = 4'h0;
  logic [31:0] rdat, dat_o;
  logic ack, servo, pos, neg, alarm, clr, merr, irq;
  logic [9:0] pins;
  logic [4:0] outs;
  logic [31:0] fsel [10];
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int seed = 32'h3D80;
  assign outs = {merr, alarm, neg, pos, servo};

  contact_host u_contact_host (.clk_i, .want_i(want), .lag_i(lag),
    .contact_o(pins));
  control_input_function_mapper u_control_input_function_mapper (
    .clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .gp_input_i(pins), .control_mode_i(mode),
    .servo_enable_o(servo), .positive_overtravel_inhibit_o(pos),
    .negative_overtravel_inhibit_o(neg), .overtravel_alarm_o(alarm),
    .deviation_clear_o(clr), .map_error_o(merr), .irq_o(irq));

  // Clock and hang guard
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    if (w && a < ADDR_OT_SETUP) fsel[a[5:2]] = d;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic logic [4:0] model(input logic [9:0] p,
      input logic [1:0] m, input logic [3:0] ot);
    logic [4:0] r;
    logic [7:0] b;
    r = 5'h00;
    for (int i = 0; i < 10; i++) begin
      b = fsel[i][8 * ((m == 2'h3) ? 0 : m) +: 8];
      if (b[6:0] == FN_SERVO) r[0] |= p[i] ^ b[7];
      if (b[6:0] == FN_POS_OT) r[1] |= p[i] ^ b[7];
      if (b[6:0] == FN_NEG_OT) r[2] |= p[i] ^ b[7];
      if (b[6:0] == FN_CLEAR && i != CLEAR_INPUT_IDX) r[4] = 1'b1;
    end
    r[3] = (r[1] | r[2]) & (ot == OT_ALARM);
    return r;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] w;
    logic [7:0] a;
    logic [3:0] ot;
    int k;
    for (int i = 0; i < 10; i++) fsel[i] = FSEL_RESET[i];
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset values and an unmapped word
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chk("fsel reset", rdat, FSEL_RESET[i]);
    end
    wb(1'b0, ADDR_OT_SETUP, 32'h0);
    chk("ot reset", rdat, 32'h1);
    wb(1'b0, ADDR_CLR_MODE, 32'h0);
    chk("clear mode reset", rdat, 32'h3);
    wb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", rdat, 32'h0);
    // Random routing, polarity, mode and contacts
    for (int t = 0; t < 40; t++) begin
      if (t > 0) begin
        for (int j = 0; j < 3; j++) begin
          k = {$random(seed)} % 5;
          w[8 * j +: 8] = {1'($random(seed)), CODES[k]};
        end
        w[31:24] = 8'h00;
        a = 8'(4 * ({$random(seed)} % 10));
        wb(1'b1, a, w);
        wb(1'b0, a, 32'h0);
        chk("fsel rw", rdat, w);
      end
      ot = ($random(seed) & 1) ? OT_ALARM : 4'h3;
      wb(1'b1, ADDR_OT_SETUP, {28'h0, ot});
      mode <= 2'($random(seed));
      want <= 10'($random(seed));
      lag <= 4'($random(seed)) & 4'h7;
      repeat (14) @(posedge clk_i);
      chk("functions", outs, model(want, mode, ot));
    end
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("synced pins", rdat[25:16], want);
    // Event, mask and write-one-to-clear
    for (int i = 0; i < 10; i++) wb(1'b1, 8'(4 * i), 32'h0);
    wb(1'b1, 8'h00, 32'h00010101);
    want <= 10'h000;
    repeat (14) @(posedge clk_i);
    wb(1'b1, ADDR_IRQ_STAT, 32'h1F);
    want <= 10'h001;
    repeat (14) @(posedge clk_i);
    chk("irq masked", irq, 1'b0);
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("ot event", rdat[EV_POS_OT], 1'b1);
    wb(1'b1, ADDR_IRQ_MASK, 32'h01);
    repeat (2) @(posedge clk_i);
    chk("irq raised", irq, 1'b1);
    wb(1'b1, ADDR_IRQ_STAT, 32'h01);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", irq, 1'b0);
    // Disabling setup value drops the inhibit with the input on
    chk("inhibit on", pos, 1'b1);
    wb(1'b1, ADDR_OT_SETUP, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("inhibit off", pos, 1'b0);
    // Clear modes on the seventh input
    wb(1'b1, 8'h18, 32'h00000007);
    mode <= 2'h0;
    for (int m = 1; m < 5; m++) begin
      wb(1'b1, ADDR_CLR_MODE, 32'(m));
      want <= 10'h000;
      repeat (14) @(posedge clk_i);
      want <= 10'h040;
      k = 0;
      repeat (16) begin
        @(posedge clk_i);
        if (clr === 1'b1) k++;
      end
      chk("clear pulse", k == 1, m > 2);
    end
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("clear event", rdat[EV_CLEAR], 1'b1);
    wrap_up();
  end
endmodule
